// [rtl/async_8bit_timer_regs.sv]
// 8-bit timer/counter with prescaler, compare unit, flags and
// asynchronous-update holding registers, reached over AHB-Lite.
// Assumes one clock hclk; the crystal input pin is sampled on hclk and its
// rising edges form the asynchronous timer source clock.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Force strobe only acts in non-PWM modes
// - Force strobe applies compare action to output
// - Forced match sets no flag, no clear
// - Force strobe bit always reads zero
// - Clock select: stop, div1..div1024 taps
// - Counter read/write; write blocks next match
// - Compare register compared continuously with counter
// - External clock enable selects input, stops oscillator
// - Async select picks I/O or timer source
// - Async change may corrupt; software rewrites
// - Async select forced zero unless RC clock
// - Async writes set per-register busy flags
// - Count reads live; others read holding
// - Compare interrupt when enabled and flagged
// - Overflow interrupt when enabled and flagged
// - Reserved bits read as zero
// - Waveform modes normal, phase, CTC, fast
// - Compare flag set on match, cleared
// - Overflow flag set on overflow, cleared
module async_8bit_timer_regs
   import timer8_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Clocking environment
   input  wire logic        crystal_input_pin,
   input  wire logic        system_clock_is_rc,
   output logic             crystal_osc_enable,
   output logic             ext_clock_buf_enable,
   // Interrupt handshake
   input  wire logic        global_irq_enable,
   input  wire logic        compare_vector_ack,
   input  wire logic        overflow_vector_ack,
   output logic             compare_irq_req,
   output logic             overflow_irq_req,
   // Waveform
   output logic             compare_output_pin
);

   function automatic logic tap_hit(input logic [2:0] cs, input logic [PRESCALE_W-1:0] pre);
      case (cs)
         CS_DIV1:    tap_hit = 1'b1;
         CS_DIV8:    tap_hit = &pre[2:0];
         CS_DIV32:   tap_hit = &pre[4:0];
         CS_DIV64:   tap_hit = &pre[5:0];
         CS_DIV128:  tap_hit = &pre[6:0];
         CS_DIV256:  tap_hit = &pre[7:0];
         CS_DIV1024: tap_hit = &pre[9:0];
         default:    tap_hit = 1'b0;
      endcase
   endfunction

   function automatic logic is_pwm(input logic [1:0] wgm);
      is_pwm = (wgm == WGM_PHASE) || (wgm == WGM_FAST);
   endfunction

   logic        rd_pend_ff;
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic [7:0]  rd_addr_ff;
   logic [7:0]  ctl_a_hold_ff;
   logic [7:0]  ctl_a_ff;
   logic [2:0]  cs_hold_ff;
   logic [2:0]  cs_ff;
   logic [7:0]  cnt_hold_ff;
   logic [7:0]  count_ff;
   logic [7:0]  cmp_hold_ff;
   logic [7:0]  cmp_ff;
   logic        external_clock_enable_ff;
   logic        as0_ff;
   logic        busy_cnt_ff;
   logic        busy_cmp_ff;
   logic        busy_ctla_ff;
   logic        busy_ctlb_ff;
   logic [1:0]  mask_ff;
   logic        cmp_flag_ff;
   logic        ovf_flag_ff;
   logic        block_ff;
   logic        count_up_ff;
   logic        xtal_prev_ff;
   logic [PRESCALE_W-1:0] pre_ff;

   logic        wr_ctla, wr_ctlb, wr_cnt, wr_cmp, wr_stat, wr_mask, wr_flags;
   logic        src_tick, timer_tick;
   logic        upd_cnt, upd_cmp, upd_ctla, upd_ctlb;
   logic        cnt_load;
   logic [7:0]  cnt_load_val;
   logic [7:0]  wbyte;
   logic [1:0]  wgm, com;
   logic [7:0]  nxt_count;
   logic        nxt_count_up;
   logic        cmp_ev, ovf_ev, bottom_ev, force_ev;
   logic        nxt_pin;
   logic [7:0]  rd_val;

   assign wbyte = hwdata[7:0];
   assign wgm   = ctl_a_ff[BIT_WGM_HI:BIT_WGM_LO];
   assign com   = ctl_a_ff[BIT_COM_HI:BIT_COM_LO];

   // Reads take one wait state so a read right after a write sees it
   // Writes need no wait state; the data phase lands at its closing edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_ff <= 1'b0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= RST_BYTE;
         rd_addr_ff <= RST_BYTE;
         hreadyout  <= 1'b1;
         hresp      <= HRESP_OKAY;
         hrdata     <= 32'h0000_0000;
      end else begin
         hresp      <= HRESP_OKAY;
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         if (rd_pend_ff) begin
            hrdata    <= {24'h00_0000, rd_val};
            hreadyout <= 1'b1;
         end else if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
               wr_pend_ff <= 1'b1;
               wr_addr_ff <= haddr[7:0];
            end else begin
               rd_pend_ff <= 1'b1;
               rd_addr_ff <= haddr[7:0];
               hreadyout  <= 1'b0;
            end
         end
      end
   end

   assign wr_ctla  = wr_pend_ff && (wr_addr_ff == OFS_CONTROL_A);
   assign wr_ctlb  = wr_pend_ff && (wr_addr_ff == OFS_CONTROL_B);
   assign wr_cnt   = wr_pend_ff && (wr_addr_ff == OFS_COUNT);
   assign wr_cmp   = wr_pend_ff && (wr_addr_ff == OFS_COMPARE_A);
   assign wr_stat  = wr_pend_ff && (wr_addr_ff == OFS_ASYNC_STAT);
   assign wr_mask  = wr_pend_ff && (wr_addr_ff == OFS_IRQ_MASK);
   assign wr_flags = wr_pend_ff && (wr_addr_ff == OFS_FLAGS);

   always_comb begin
      case (rd_addr_ff)
         OFS_CONTROL_A:  rd_val = ctl_a_hold_ff & 8'hC3;
         OFS_CONTROL_B:  rd_val = {5'h00, cs_hold_ff};
         OFS_COUNT:      rd_val = count_ff;
         OFS_COMPARE_A:  rd_val = cmp_hold_ff;
         OFS_ASYNC_STAT: rd_val = {1'b0, external_clock_enable_ff, as0_ff, busy_cnt_ff, busy_cmp_ff,
                                   1'b0, busy_ctla_ff, busy_ctlb_ff};
         OFS_IRQ_MASK:   rd_val = {6'h00, mask_ff};
         OFS_FLAGS:      rd_val = {6'h00, cmp_flag_ff, ovf_flag_ff};
         default:        rd_val = RST_BYTE;
      endcase
   end

   // Timer source: hclk when synchronous, sampled crystal edges when asynchronous
   assign src_tick   = as0_ff ? (crystal_input_pin && !xtal_prev_ff) : 1'b1;
   assign timer_tick = src_tick && tap_hit(cs_ff, pre_ff);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xtal_prev_ff <= 1'b0;
         pre_ff       <= '0;
      end else begin
         xtal_prev_ff <= crystal_input_pin;
         if (src_tick) begin
            pre_ff <= pre_ff + 1'b1;
         end
      end
   end

   // Clock source selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         external_clock_enable_ff <= 1'b0;
         as0_ff   <= 1'b0;
      end else begin
         // Switching async select leaves count, compare and control A as they
         // are; software is still expected to rewrite them after the switch
         if (wr_stat) begin
            external_clock_enable_ff <= wbyte[BIT_EXT_CLK];
            as0_ff   <= wbyte[BIT_ASYNC_SEL] && system_clock_is_rc;
         end else if (!system_clock_is_rc) begin
            as0_ff <= 1'b0;
         end
      end
   end

   // A holding register reaches the timer on the next source edge
   // Limitation: a flag still busy when async select drops stays set until
   // async select returns, so software lets it clear before leaving async mode
   assign upd_cnt  = as0_ff && src_tick && busy_cnt_ff;
   assign upd_cmp  = as0_ff && src_tick && busy_cmp_ff;
   assign upd_ctla = as0_ff && src_tick && busy_ctla_ff;
   assign upd_ctlb = as0_ff && src_tick && busy_ctlb_ff;

   // Busy flags: a new write wins over the clearing update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_cnt_ff  <= 1'b0;
         busy_cmp_ff  <= 1'b0;
         busy_ctla_ff <= 1'b0;
         busy_ctlb_ff <= 1'b0;
      end else begin
         busy_cnt_ff  <= (wr_cnt && as0_ff) || (busy_cnt_ff && !upd_cnt);
         busy_cmp_ff  <= (wr_cmp && as0_ff) || (busy_cmp_ff && !upd_cmp);
         busy_ctla_ff <= (wr_ctla && as0_ff) || (busy_ctla_ff && !upd_ctla);
         busy_ctlb_ff <= (wr_ctlb && as0_ff) || (busy_ctlb_ff && !upd_ctlb);
      end
   end

   // Holding and active copies of control and compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_a_hold_ff <= RST_BYTE;
         ctl_a_ff      <= RST_BYTE;
         cs_hold_ff    <= CS_STOP;
         cs_ff         <= CS_STOP;
         cmp_hold_ff   <= RST_BYTE;
         cmp_ff        <= RST_BYTE;
         cnt_hold_ff   <= RST_BYTE;
         mask_ff       <= 2'h0;
      end else begin
         if (wr_ctla) ctl_a_hold_ff <= wbyte & 8'hC3;
         if (wr_ctla && !as0_ff) ctl_a_ff <= wbyte & 8'hC3;
         else if (upd_ctla) ctl_a_ff <= ctl_a_hold_ff;
         if (wr_ctlb) cs_hold_ff <= wbyte[BIT_CS_HI:0];
         if (wr_ctlb && !as0_ff) cs_ff <= wbyte[BIT_CS_HI:0];
         else if (upd_ctlb) cs_ff <= cs_hold_ff;
         if (wr_cmp) cmp_hold_ff <= wbyte;
         if (wr_cmp && !as0_ff) cmp_ff <= wbyte;
         else if (upd_cmp) cmp_ff <= cmp_hold_ff;
         if (wr_cnt) cnt_hold_ff <= wbyte;
         if (wr_mask) mask_ff <= wbyte[1:0];
      end
   end

   assign cnt_load     = (wr_cnt && !as0_ff) || upd_cnt;
   assign cnt_load_val = as0_ff ? cnt_hold_ff : wbyte;
   // Forced match never reaches flag or counter clear
   assign force_ev     = wr_ctlb && wbyte[BIT_FORCE_STROBE] && !is_pwm(wgm);

   always_comb begin
      nxt_count    = count_ff;
      nxt_count_up = count_up_ff;
      cmp_ev       = 1'b0;
      ovf_ev       = 1'b0;
      bottom_ev    = 1'b0;
      if (cnt_load) begin
         nxt_count = cnt_load_val;
      end else if (timer_tick) begin
         cmp_ev = (count_ff == cmp_ff) && !block_ff;
         case (wgm)
            WGM_CTC: begin
               nxt_count = cmp_ev ? CNT_BOTTOM : count_ff + 8'h01;
               ovf_ev    = (count_ff == CNT_MAX);
            end
            WGM_PHASE: begin
               if (count_up_ff) begin
                  if (count_ff == CNT_MAX) begin
                     nxt_count_up = 1'b0;
                     nxt_count    = count_ff - 8'h01;
                  end else begin
                     nxt_count = count_ff + 8'h01;
                  end
               end else if (count_ff == CNT_BOTTOM) begin
                  nxt_count_up = 1'b1;
                  nxt_count    = count_ff + 8'h01;
                  ovf_ev       = 1'b1;
               end else begin
                  nxt_count = count_ff - 8'h01;
               end
            end
            default: begin
               nxt_count = count_ff + 8'h01;
               ovf_ev    = (count_ff == CNT_MAX);
               bottom_ev = (count_ff == CNT_MAX) && (wgm == WGM_FAST);
            end
         endcase
      end
   end

   // Output action on match, bottom or forced strobe
   always_comb begin
      nxt_pin = compare_output_pin;
      if (!is_pwm(wgm)) begin
         if (cmp_ev || force_ev) begin
            case (com)
               2'h1:    nxt_pin = !compare_output_pin;
               2'h2:    nxt_pin = 1'b0;
               2'h3:    nxt_pin = 1'b1;
               default: nxt_pin = compare_output_pin;
            endcase
         end
      end else if (com[1]) begin
         if (wgm == WGM_FAST) begin
            if (cmp_ev) nxt_pin = com[0];
            else if (bottom_ev) nxt_pin = !com[0];
         end else if (cmp_ev) begin
            nxt_pin = count_up_ff ? com[0] : !com[0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_ff           <= RST_BYTE;
         count_up_ff        <= 1'b1;
         block_ff           <= 1'b0;
         compare_output_pin <= 1'b0;
      end else begin
         count_ff           <= nxt_count;
         count_up_ff        <= nxt_count_up;
         compare_output_pin <= nxt_pin;
         if (cnt_load) block_ff <= 1'b1;
         else if (timer_tick) block_ff <= 1'b0;
      end
   end

   // Flags: a hardware set wins over a same-cycle clear
   // so an event in the clearing cycle is never lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_flag_ff <= 1'b0;
         ovf_flag_ff <= 1'b0;
      end else begin
         cmp_flag_ff <= cmp_ev || (cmp_flag_ff && !compare_vector_ack
                        && !(wr_flags && wbyte[BIT_CMP_IRQ]));
         ovf_flag_ff <= ovf_ev || (ovf_flag_ff && !overflow_vector_ack
                        && !(wr_flags && wbyte[BIT_OVF_IRQ]));
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_irq_req      <= 1'b0;
         overflow_irq_req     <= 1'b0;
         crystal_osc_enable   <= 1'b1;
         ext_clock_buf_enable <= 1'b0;
      end else begin
         compare_irq_req      <= cmp_flag_ff && mask_ff[BIT_CMP_IRQ] && global_irq_enable;
         overflow_irq_req     <= ovf_flag_ff && mask_ff[BIT_OVF_IRQ] && global_irq_enable;
         crystal_osc_enable   <= !external_clock_enable_ff;
         ext_clock_buf_enable <= external_clock_enable_ff && as0_ff;
      end
   end

endmodule

`default_nettype wire

// [rtl/timer8_pkg.sv]
// Constants for the 8-bit timer/counter with asynchronous clocking option.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package timer8_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL_A  = 8'h00;
   localparam logic [7:0] OFS_CONTROL_B  = 8'h04;
   localparam logic [7:0] OFS_COUNT      = 8'h08;
   localparam logic [7:0] OFS_COMPARE_A  = 8'h0C;
   localparam logic [7:0] OFS_ASYNC_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
   localparam logic [7:0] OFS_FLAGS      = 8'h18;
   // Field positions
   localparam int BIT_FORCE_STROBE = 7;
   localparam int BIT_COM_HI       = 7;
   localparam int BIT_COM_LO       = 6;
   localparam int BIT_WGM_HI       = 1;
   localparam int BIT_WGM_LO       = 0;
   localparam int BIT_CS_HI        = 2;
   localparam int BIT_EXT_CLK      = 6;
   localparam int BIT_ASYNC_SEL    = 5;
   localparam int BIT_CNT_BUSY     = 4;
   localparam int BIT_CMP_BUSY     = 3;
   localparam int BIT_CTLA_BUSY    = 1;
   localparam int BIT_CTLB_BUSY    = 0;
   localparam int BIT_CMP_IRQ      = 1;
   localparam int BIT_OVF_IRQ      = 0;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Count range
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   // Waveform modes
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PHASE  = 2'h1;
   localparam logic [1:0] WGM_CTC    = 2'h2;
   localparam logic [1:0] WGM_FAST   = 2'h3;
   // Clock select codes
   localparam logic [2:0] CS_STOP  = 3'h0;
   localparam logic [2:0] CS_DIV1  = 3'h1;
   localparam logic [2:0] CS_DIV8  = 3'h2;
   localparam logic [2:0] CS_DIV32 = 3'h3;
   localparam logic [2:0] CS_DIV64 = 3'h4;
   localparam logic [2:0] CS_DIV128 = 3'h5;
   localparam logic [2:0] CS_DIV256 = 3'h6;
   localparam logic [2:0] CS_DIV1024 = 3'h7;
   localparam int PRESCALE_W = 10;
   // Bus
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// [bench/async_8bit_timer_regs_monitor.sv]
// Checker for the 8-bit timer register block, bound to its ports.
// Assumes a single hclk domain with active-low asynchronous reset hresetn.
`timescale 1ns/1ps
`default_nettype none
module timer_monitor (
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   // Clocking and interrupts
   input wire logic        system_clock_is_rc,
   input wire logic        crystal_osc_enable,
   input wire logic        ext_clock_buf_enable,
   input wire logic        global_irq_enable,
   input wire logic        compare_irq_req,
   input wire logic        overflow_irq_req
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   read_one_wait_a: assert property ((hsel && hready && htrans[1] && !hwrite) |=>
      !hreadyout ##1 hreadyout) else $error("read wait state not exactly one cycle");
   wait_only_read_a: assert property ($fell(hreadyout) |->
      $past(hsel && hready && htrans[1] && !hwrite)) else $error("wait state without read");
   upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   osc_buf_excl_a: assert property (ext_clock_buf_enable |-> !crystal_osc_enable)
      else $error("oscillator runs with external clock buffer on");
   async_forced_a: assert property (!system_clock_is_rc [*3] |-> !ext_clock_buf_enable)
      else $error("async select kept without RC system clock");
   cmp_irq_gate_a: assert property (compare_irq_req |-> $past(global_irq_enable))
      else $error("compare request without global enable");
   ovf_irq_gate_a: assert property (overflow_irq_req |-> $past(global_irq_enable))
      else $error("overflow request without global enable");
   irq_drop_a: assert property ($fell(global_irq_enable) |=>
      !compare_irq_req && !overflow_irq_req) else $error("request stays after global disable");
endmodule

bind async_8bit_timer_regs timer_monitor mon (
   .hclk                 (hclk),
   .hresetn              (hresetn),
   .hsel                 (hsel),
   .htrans               (htrans),
   .hwrite               (hwrite),
   .hready               (hready),
   .hreadyout            (hreadyout),
   .hrdata               (hrdata),
   .system_clock_is_rc   (system_clock_is_rc),
   .crystal_osc_enable   (crystal_osc_enable),
   .ext_clock_buf_enable (ext_clock_buf_enable),
   .global_irq_enable    (global_irq_enable),
   .compare_irq_req      (compare_irq_req),
   .overflow_irq_req     (overflow_irq_req)
);
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the 8-bit timer register block over AHB-Lite.
// Assumes the block is the only slave, so its hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import timer8_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, xtal, sys_rc, gie, cack, oack, p;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire         hreadyout, hresp, osc_en, buf_en, cirq, oirq, pin;
   wire  [31:0] hrdata;
   int          n_mismatch, tests_run;
   int          div [8] = '{1, 1, 8, 32, 64, 128, 256, 1024};

   async_8bit_timer_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crystal_input_pin(xtal),
      .system_clock_is_rc(sys_rc), .crystal_osc_enable(osc_en), .ext_clock_buf_enable(buf_en),
      .global_irq_enable(gie), .compare_vector_ack(cack), .overflow_vector_ack(oack),
      .compare_irq_req(cirq), .overflow_irq_req(oirq), .compare_output_pin(pin));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic tally_and_finish();
      $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Bounded so a slave that never answers ends the run instead of hanging
   task automatic wait_ready();
      int i;
      i = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 20) begin
            n_mismatch++;
            tally_and_finish();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      check(rd, exp);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      xtal = 1'b0;
      sys_rc = 1'b0;
      gie = 1'b0;
      cack = 1'b0;
      oack = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      tick(16);
      hresetn <= 1'b1;
      @(posedge hclk);
      check(osc_en, 1);
      for (int a = 0; a <= 28; a += 4) rdchk(8'(a), 32'h0);
      check(hresp, 32'(HRESP_OKAY));
      wr(OFS_CONTROL_B, 32'hFF);
      rdchk(OFS_CONTROL_B, 32'h07);
      wr(OFS_CONTROL_B, 32'h00);
      wr(OFS_IRQ_MASK, 32'hFF);
      rdchk(OFS_IRQ_MASK, 32'h03);
      wr(OFS_ASYNC_STAT, 32'hFF);
      rdchk(OFS_ASYNC_STAT, 32'h40);
      check({osc_en, buf_en}, 2'b00);
      sys_rc <= 1'b1;
      wr(OFS_ASYNC_STAT, 32'h60);
      rdchk(OFS_ASYNC_STAT, 32'h60);
      check({osc_en, buf_en}, 2'b01);
      wr(OFS_ASYNC_STAT, 32'h00);
      // Prescaler is free running, so each divided tap may gain one tick of phase; div1 is allowed up to 7 counts
      for (int c = 1; c < 8; c++) begin
         wr(OFS_COUNT, 32'h0);
         wr(OFS_CONTROL_B, 32'(c));
         tick(4 * div[c]);
         wr(OFS_CONTROL_B, 32'h0);
         bus(OFS_COUNT, 1'b0, 32'h0);
         check(32'(rd >= 4 && rd <= (c == 1 ? 7 : 5)), 32'h1);
      end
      wr(OFS_COUNT, 32'h5A);
      tick(20);
      rdchk(OFS_COUNT, 32'h5A);
      wr(OFS_COUNT, 32'hFE);
      wr(OFS_FLAGS, 32'h03);
      wr(OFS_IRQ_MASK, 32'h01);
      gie <= 1'b1;
      wr(OFS_CONTROL_B, 32'h1);
      tick(4);
      wr(OFS_CONTROL_B, 32'h0);
      bus(OFS_FLAGS, 1'b0, 32'h0);
      check(rd & 32'h1, 32'h1);
      check(oirq, 1);
      bus(OFS_COUNT, 1'b0, 32'h0);
      check(32'(rd < 8), 32'h1);
      gie <= 1'b0;
      tick(3);
      check(oirq, 0);
      gie <= 1'b1;
      oack <= 1'b1;
      @(posedge hclk);
      oack <= 1'b0;
      tick(3);
      check(oirq, 0);
      wr(OFS_COMPARE_A, 32'h20);
      wr(OFS_COUNT, 32'h1E);
      wr(OFS_FLAGS, 32'h03);
      rdchk(OFS_FLAGS, 32'h0);
      wr(OFS_IRQ_MASK, 32'h02);
      wr(OFS_CONTROL_B, 32'h1);
      tick(4);
      wr(OFS_CONTROL_B, 32'h0);
      bus(OFS_FLAGS, 1'b0, 32'h0);
      check(rd & 32'h2, 32'h2);
      check(cirq, 1);
      cack <= 1'b1;
      @(posedge hclk);
      cack <= 1'b0;
      rdchk(OFS_FLAGS, 32'h0);
      wr(OFS_COUNT, 32'h20);
      wr(OFS_CONTROL_B, 32'h1);
      wr(OFS_CONTROL_B, 32'h0);
      bus(OFS_FLAGS, 1'b0, 32'h0);
      check(rd & 32'h2, 32'h0);
      wr(OFS_COUNT, 32'h55);
      // Set then clear, so each forced action moves the pin
      wr(OFS_CONTROL_A, 32'hC0);
      wr(OFS_CONTROL_B, 32'h80);
      tick(2);
      check(pin, 1);
      wr(OFS_CONTROL_A, 32'h80);
      wr(OFS_CONTROL_B, 32'h80);
      tick(2);
      check(pin, 0);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_CONTROL_A, 32'h40 | 32'(m));
         p = pin;
         wr(OFS_CONTROL_B, 32'h80);
         tick(2);
         check(pin, p ^ (m == 0 || m == 2));
      end
      rdchk(OFS_COUNT, 32'h55);
      rdchk(OFS_FLAGS, 32'h0);
      wr(OFS_ASYNC_STAT, 32'h20);
      wr(OFS_COMPARE_A, 32'h33);
      wr(OFS_COUNT, 32'h44);
      wr(OFS_CONTROL_A, 32'h00);
      wr(OFS_CONTROL_B, 32'h00);
      rdchk(OFS_ASYNC_STAT, 32'h3B);
      rdchk(OFS_COMPARE_A, 32'h33);
      rdchk(OFS_COUNT, 32'h55);
      xtal <= 1'b1;
      tick(4);
      xtal <= 1'b0;
      tick(4);
      rdchk(OFS_ASYNC_STAT, 32'h20);
      rdchk(OFS_COUNT, 32'h44);
      wr(OFS_ASYNC_STAT, 32'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
